// file: logic/gpo_pkg.sv
/*
 * gpo_pkg: register map, reset values and widths for the general purpose
 * output alias and input value block of one 32-pin port group.
 * Assumes an APB master with 32-bit data and word aligned byte addresses.
 */
// Function
// [R1] clear alias ones force output bits low
// [R2] output pins drive low after clear
// [R3] clear selects pull-down on pulled inputs
// [R4] set alias ones force output bits high
// [R5] set selects pull-up on pulled inputs
// [R6] toggle alias ones invert output bits
// [R7] toggle swaps pull direction on pulled inputs
// [R8] zero bits leave value and pull unchanged
// [R9] output value and aliases show same value
// [R10] read-only input value register, resets zero
// [R11] aliases reset zero, span all 32 pins
// [R12] input bits follow sampled pin levels
// [R13] direction picks drive level or pull select
// [R14] write guard blocks output value writes
package gpo_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int GPO_PINS = 32;
    localparam int GPO_ADDR_W = 8;
    localparam int GPO_SYNC_STAGES = 2;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] GPO_OFS_DIRECTION = 8'h00;
    localparam logic [7:0] GPO_OFS_OUT_VALUE = 8'h10;
    localparam logic [7:0] GPO_OFS_CLEAR = 8'h14;
    localparam logic [7:0] GPO_OFS_SET = 8'h18;
    localparam logic [7:0] GPO_OFS_TOGGLE = 8'h1C;
    localparam logic [7:0] GPO_OFS_INPUT = 8'h20;
    localparam logic [7:0] GPO_OFS_PULL_ENABLE = 8'h30;
    localparam logic [7:0] GPO_OFS_WRITE_GUARD = 8'h34;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int GPO_GUARD_BIT = 0;
    localparam logic [31:0] GPO_RST_WORD = 32'h0000_0000;
    localparam logic GPO_RST_GUARD = 1'b0;

    // kind of register access decoded from the address
    typedef enum logic [2:0] {
        GPO_ACC_NONE = 3'b000,
        GPO_ACC_PLAIN = 3'b001,
        GPO_ACC_CLEAR = 3'b010,
        GPO_ACC_SET = 3'b011,
        GPO_ACC_TOGGLE = 3'b100
    } gpo_acc_type;

endpackage

// file: logic/gpo_samp_if.sv
/*
 * gpo_samp_if: carries the synchronised pin levels from the input sampler
 * to the register core. Assumes both ends sit on the same pclk.
 */
`timescale 1ns/1ns
interface gpo_samp_if #(parameter int W = 32);
    logic [W-1:0] level;

    modport sampler (output level);
    modport core (input level);
endinterface

// file: logic/gpo_in_sampler.sv
/*
 * gpo_in_sampler: two flip-flop synchroniser for every pad input.
 * Assumes pads change with no relation to pclk; adds two cycles of delay.
 */
`timescale 1ns/1ns
module gpo_in_sampler
    import gpo_pkg::*;
#(
    parameter int W = GPO_PINS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic [W-1:0] pad_in,
    gpo_samp_if.sampler samp
);

    // ****************************************************************
    // synchroniser
    // ****************************************************************
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else if (pclk_en)
        begin
            meta_reg <= pad_in;
            sync_reg <= meta_reg; // [R12]
        end
    end

    assign samp.level = sync_reg;

endmodule // gpo_in_sampler

// file: logic/gpo_port.sv
/*
 * gpo_port: output value register with clear, set and toggle aliases, the
 * direction and pull enable controls, a write guard and the input value
 * register of one port group, reached as an APB slave.
 * Assumes one clock pclk and asynchronous active low reset presetn; pads
 * and pull resistors are outside and follow pad_out, pad_oe, pull_*.
 */
`timescale 1ns/1ns
module gpo_port
    import gpo_pkg::*;
#(
    parameter int PINS = GPO_PINS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GPO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pull_enable,
    output logic [PINS-1:0] pull_up
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the register map packs one bit per pin into a 32-bit word
    if (PINS < 1 || PINS > 32)
    begin : g_bad_pins
        $error("gpo_port: PINS must be between 1 and 32");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    logic [PINS-1:0] out_reg;
    logic [PINS-1:0] out_next;
    logic [PINS-1:0] dir_reg;
    logic [PINS-1:0] pull_en_reg;
    logic [PINS-1:0] in_reg;
    logic guard_reg;
    logic rd_held_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_word;
    logic [PINS-1:0] wmask;
    logic mapped;
    logic setup_phase;
    logic access_phase;
    logic wr_fire;
    logic wr_allowed;
    gpo_acc_type acc;

    gpo_samp_if #(.W(PINS)) samp ();

    // ****************************************************************
    // input sampler
    // ****************************************************************
    gpo_in_sampler #(.W(PINS)) u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .pad_in(pad_in),
        .samp(samp.sampler)
    );

    // ****************************************************************
    // bus phases
    // ****************************************************************
    // a frozen clock enable also stalls the bus, so no write is lost
    assign setup_phase = psel && !penable && pclk_en;
    assign access_phase = psel && penable && pclk_en;
    assign wr_fire = access_phase && pwrite && mapped;
    // the guard register itself stays writable so software can unlock
    assign wr_allowed = wr_fire && !guard_reg; // [R14]
    assign wmask = pwdata[PINS-1:0];

    // address decode
    always_comb
    begin
        mapped = 1'b1;
        acc = GPO_ACC_NONE;
        case (paddr)
            GPO_OFS_OUT_VALUE: acc = GPO_ACC_PLAIN;
            GPO_OFS_CLEAR: acc = GPO_ACC_CLEAR;
            GPO_OFS_SET: acc = GPO_ACC_SET;
            GPO_OFS_TOGGLE: acc = GPO_ACC_TOGGLE;
            GPO_OFS_DIRECTION: acc = GPO_ACC_NONE;
            GPO_OFS_INPUT: acc = GPO_ACC_NONE;
            GPO_OFS_PULL_ENABLE: acc = GPO_ACC_NONE;
            GPO_OFS_WRITE_GUARD: acc = GPO_ACC_NONE;
            default: mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // output value and its aliases
    // ****************************************************************
    // one stored value behind four addresses, no read-modify-write needed
    always_comb
    begin
        out_next = out_reg;
        case (acc)
            GPO_ACC_PLAIN: out_next = wmask;
            GPO_ACC_CLEAR: out_next = out_reg & ~wmask; // [R1] [R8]
            GPO_ACC_SET: out_next = out_reg | wmask; // [R4] [R8]
            GPO_ACC_TOGGLE: out_next = out_reg ^ wmask; // [R6] [R8]
            GPO_ACC_NONE: out_next = out_reg;
            default: out_next = out_reg;
        endcase
    end

    // output value register, all aliases reset with it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_reg <= GPO_RST_WORD[PINS-1:0]; // [R11]
        end
        else if (wr_allowed)
        begin
            out_reg <= out_next; // [R9]
        end
    end

    // ****************************************************************
    // direction, pull enable and guard
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_reg <= GPO_RST_WORD[PINS-1:0];
            pull_en_reg <= GPO_RST_WORD[PINS-1:0];
        end
        else if (wr_allowed)
        begin
            if (paddr == GPO_OFS_DIRECTION)
            begin
                dir_reg <= wmask;
            end
            if (paddr == GPO_OFS_PULL_ENABLE)
            begin
                pull_en_reg <= wmask;
            end
        end
    end

    // write guard bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            guard_reg <= GPO_RST_GUARD;
        end
        else if (wr_fire && paddr == GPO_OFS_WRITE_GUARD)
        begin
            guard_reg <= pwdata[GPO_GUARD_BIT];
        end
    end

    // ****************************************************************
    // input value register
    // ****************************************************************
    // no write path exists, so bus writes here have no effect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_reg <= GPO_RST_WORD[PINS-1:0]; // [R10]
        end
        else if (pclk_en)
        begin
            in_reg <= samp.level; // [R12]
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // read word built from the address held in the setup cycle
    always_comb
    begin
        rd_word = GPO_RST_WORD;
        case (paddr)
            GPO_OFS_OUT_VALUE,
            GPO_OFS_CLEAR,
            GPO_OFS_SET,
            GPO_OFS_TOGGLE: rd_word[PINS-1:0] = out_reg; // [R9]
            GPO_OFS_DIRECTION: rd_word[PINS-1:0] = dir_reg;
            GPO_OFS_PULL_ENABLE: rd_word[PINS-1:0] = pull_en_reg;
            GPO_OFS_INPUT: rd_word[PINS-1:0] = in_reg; // [R10]
            GPO_OFS_WRITE_GUARD: rd_word[GPO_GUARD_BIT] = guard_reg;
            default: rd_word = GPO_RST_WORD;
        endcase
    end

    // captured in setup, or in the first enabled access cycle when the
    // setup edge fell while the clock enable was low, so the access
    // cycle that completes always presents the word of this transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= GPO_RST_WORD;
        end
        else if ((setup_phase || (access_phase && !rd_held_reg)) && !pwrite)
        begin
            prdata_reg <= rd_word;
        end
    end

    // set once the read word of the current transfer is held; cleared by
    // the completing edge so the next read captures again
    // limitation: a read after a frozen setup edge takes one wait state,
    // traded for never returning a word from an earlier transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_held_reg <= 1'b0;
        end
        else if (pclk_en)
        begin
            rd_held_reg <= psel && !pwrite && !(penable && rd_held_reg);
        end
    end

    // ****************************************************************
    // bus handshake and pads
    // ****************************************************************
    // writes complete at once; a read completes once its word is held,
    // which costs one wait state only after a frozen setup edge
    assign pready = access_phase && (pwrite || rd_held_reg);
    // the error answer stands with pready, where the master samples it
    assign pslverr = pready && !mapped;
    assign prdata = prdata_reg;

    // direction decides drive level or pull selection per pin
    assign pad_out = out_reg; // [R2]
    assign pad_oe = dir_reg; // [R13]
    assign pull_enable = ~dir_reg & pull_en_reg; // [R13]
    assign pull_up = out_reg; // [R3] [R5] [R7]

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic alias_wr;
    assign alias_wr = wr_fire && (acc != GPO_ACC_NONE) && (acc != GPO_ACC_PLAIN);

    AST_CLEAR_ZERO: assert property ( // [R1]
        wr_allowed && acc == GPO_ACC_CLEAR
        |=> (out_reg & $past(wmask)) == '0
            && (out_reg & ~$past(wmask)) == ($past(out_reg) & ~$past(wmask)))
        else $error("clear alias did not clear selected bits");

    AST_CLEAR_DRIVE_LOW: assert property ( // [R2]
        wr_allowed && acc == GPO_ACC_CLEAR
        |=> (pad_out & pad_oe & $past(wmask)) == '0)
        else $error("output pin not driven low after clear");

    AST_CLEAR_PULL_DOWN: assert property ( // [R3]
        wr_allowed && acc == GPO_ACC_CLEAR
        |=> (pull_enable & pull_up & $past(wmask)) == '0)
        else $error("pulled input not pulled down after clear");

    AST_SET_ONE: assert property ( // [R4]
        wr_allowed && acc == GPO_ACC_SET
        |=> (pad_out & $past(wmask)) == $past(wmask))
        else $error("set alias did not set selected bits");

    AST_SET_PULL_UP: assert property ( // [R5]
        wr_allowed && acc == GPO_ACC_SET
        |=> (pull_enable & ~pull_up & $past(wmask)) == '0)
        else $error("pulled input not pulled up after set");

    AST_TOGGLE_INVERT: assert property ( // [R6]
        wr_allowed && acc == GPO_ACC_TOGGLE
        |=> out_reg == ($past(out_reg) ^ $past(wmask)))
        else $error("toggle alias did not invert selected bits");

    AST_TOGGLE_PULL: assert property ( // [R7]
        wr_allowed && acc == GPO_ACC_TOGGLE && (pull_enable & wmask) != '0
        |=> (pull_up & pull_enable & $past(wmask))
            == (~$past(pull_up) & pull_enable & $past(wmask)))
        else $error("pull direction not swapped by toggle");

    AST_ZERO_KEEPS: assert property ( // [R8]
        alias_wr && wmask == '0 |=> $stable(out_reg) && $stable(pull_up))
        else $error("zero write to an alias changed the value");

    AST_ALIAS_READBACK: assert property ( // [R9]
        pready && !pwrite && acc != GPO_ACC_NONE |-> prdata[PINS-1:0] == out_reg)
        else $error("alias read differs from output value");

    // a frozen setup edge must not let the read complete with an old word
    AST_READ_AFTER_CAPTURE: assert property ( // [R9]
        psel && !penable && !pwrite && !pclk_en ##1 psel && penable |-> !pready)
        else $error("read completed before its word was captured");

    AST_INPUT_RO: assert property ( // [R10]
        wr_fire && paddr == GPO_OFS_INPUT |=> in_reg == $past(samp.level))
        else $error("input value register took a bus write");

    AST_RESET_ZERO: assert property ( // [R11]
        $rose(presetn) |-> out_reg == '0 && in_reg == '0)
        else $error("registers not zero after reset");

    AST_INPUT_FOLLOWS: assert property ( // [R12]
        (pclk_en && $stable(pad_in)) [*4] |-> in_reg == pad_in)
        else $error("input value does not follow a steady pin");

    AST_DIR_ROLE: assert property ( // [R13]
        pad_oe == dir_reg && (pull_enable & dir_reg) == '0)
        else $error("direction does not select drive or pull role");

    AST_GUARD_BLOCKS: assert property ( // [R14]
        guard_reg && wr_fire && acc != GPO_ACC_NONE |=> $stable(out_reg))
        else $error("guarded write changed the output value");

    COV_CLEAR: cover property (wr_allowed && acc == GPO_ACC_CLEAR && wmask != '0);
    COV_TOGGLE_TWICE: cover property (
        wr_allowed && acc == GPO_ACC_TOGGLE ##[1:8] wr_allowed && acc == GPO_ACC_TOGGLE);
    COV_GUARDED: cover property (guard_reg && wr_fire && acc == GPO_ACC_SET);
    COV_UNMAPPED: cover property (pslverr);
    // a read whose setup edge was frozen
    COV_STALLED_READ: cover property (
        psel && !penable && !pwrite && !pclk_en ##[1:8] pready && !pwrite);

endmodule // gpo_port

// file: test/gpo_pad_model.sv
/*
 * gpo_pad_model: pad ring and outside world of one 32-pin port group.
 * Assumes one pclk; the bench chooses which pads an outside driver holds.
 */
`timescale 1ns/1ns
module gpo_pad_model
    import gpo_pkg::*;
(
    input wire logic pclk,
    input wire logic [GPO_PINS-1:0] pad_out,
    input wire logic [GPO_PINS-1:0] pad_oe,
    input wire logic [GPO_PINS-1:0] pull_enable,
    input wire logic [GPO_PINS-1:0] pull_up,
    input wire logic [GPO_PINS-1:0] ext_en,
    input wire logic [GPO_PINS-1:0] ext_val,
    output logic [GPO_PINS-1:0] pad_in
);
    // ****************************************************************
    // pad levels
    // ****************************************************************
    logic [GPO_PINS-1:0] float_reg = '0;

    // an undriven pad wanders every cycle, so no stale level can pass
    always_ff @(posedge pclk)
        float_reg <= ~float_reg;

    // own driver wins, then the outside driver, then the pull resistor
    always_comb
        pad_in = (pad_oe & pad_out)
            | (~pad_oe & ext_en & ext_val)
            | (~pad_oe & ~ext_en & pull_enable & pull_up)
            | (~pad_oe & ~ext_en & ~pull_enable & float_reg);
endmodule // gpo_pad_model

// file: test/gpo_port_tb.sv
/*
 * gpo_port_tb: self-checking bench of the port group, an APB master and
 * a reference model. Assumes the pad model on the far side.
 */
`timescale 1ns/1ns
module gpo_port_tb
    import gpo_pkg::*;
;
    // ****************************************************************
    // signals and reference state
    // ****************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pclk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [GPO_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] pad_in, pad_out, pad_oe, pull_enable, pull_up;
    logic [31:0] ext_en = '1;
    logic [31:0] ext_val = '0;
    logic [31:0] out_m = '0, dir_m = '0, pen_m = '0, rdata, known;
    logic guard_m = 1'b0;
    logic rerr;
    logic en_rand = 1'b0;
    logic [7:0] alias_ofs [4] = '{GPO_OFS_OUT_VALUE, GPO_OFS_CLEAR, GPO_OFS_SET, GPO_OFS_TOGGLE};
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;

    always #10 pclk = ~pclk;

    gpo_port #(.PINS(GPO_PINS)) dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pull_enable(pull_enable), .pull_up(pull_up));

    gpo_pad_model pads (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_enable(pull_enable), .pull_up(pull_up), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    // clock enable stalls the slave at random while asked to
    always @(posedge pclk)
        pclk_en <= en_rand ? ($urandom % 4 != 0) : 1'b1;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; the answer is taken at the rising edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ok = 1'b0;
        while (!ok)
        begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // write and update the reference model
    task automatic mw(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (!guard_m)
            case (a)
                GPO_OFS_DIRECTION: dir_m = d;
                GPO_OFS_OUT_VALUE: out_m = d;
                GPO_OFS_CLEAR: out_m &= ~d;
                GPO_OFS_SET: out_m |= d;
                GPO_OFS_TOGGLE: out_m ^= d;
                GPO_OFS_PULL_ENABLE: pen_m = d;
                default: ;
            endcase
        if (a == GPO_OFS_WRITE_GUARD)
            guard_m = d[0];
    endtask

    // every view of the output value and the pad controls against the model
    task automatic verify;
        foreach (alias_ofs[i])
        begin
            apb(1'b0, alias_ofs[i], 32'h0000_0000);
            check(rdata, out_m);
        end
        check(pad_out, out_m);
        check(pull_up, out_m);
        check(pad_oe, dir_m);
        check(pull_enable, ~dir_m & pen_m);
    endtask

    // a hang ends the run as a failure
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            final_report();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(85198));
        // reset values; pads held low so the input word is known
        for (int i = 1; i < 4; i++)
        begin
            apb(1'b0, alias_ofs[i], 32'h0000_0000);
            check(rdata, 32'h0000_0000);
        end
        apb(1'b0, GPO_OFS_INPUT, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        // alias traffic with slave stalls; zero words keep the value
        en_rand <= 1'b1;
        mw(GPO_OFS_SET, 32'hFFFF_FFFF);
        for (int i = 1; i < 4; i++)
            mw(alias_ofs[i], 32'h0000_0000);
        verify();
        repeat (40)
        begin
            mw(alias_ofs[1 + $urandom % 3], $urandom);
            verify();
        end
        en_rand <= 1'b0;
        // direction, pulls and pad levels seen through the input word
        repeat (25)
        begin
            ext_en <= $urandom;
            ext_val <= $urandom;
            mw(GPO_OFS_DIRECTION, $urandom);
            mw(GPO_OFS_PULL_ENABLE, $urandom);
            mw(alias_ofs[1 + $urandom % 3], $urandom);
            mw(GPO_OFS_INPUT, $urandom);
            verify();
            repeat (4) @(posedge pclk);
            apb(1'b0, GPO_OFS_INPUT, 32'h0000_0000);
            known = dir_m | ext_en | pen_m;
            check(rdata & known, ((dir_m & out_m) | (~dir_m & ext_en & ext_val)
                | (~dir_m & ~ext_en & out_m)) & known);
        end
        // guarded writes leave the value alone
        mw(GPO_OFS_WRITE_GUARD, 32'h0000_0001);
        mw(GPO_OFS_TOGGLE, 32'hFFFF_FFFF);
        mw(GPO_OFS_OUT_VALUE, ~out_m);
        verify();
        mw(GPO_OFS_WRITE_GUARD, 32'h0000_0000);
        mw(GPO_OFS_TOGGLE, 32'hA5A5_5A5A);
        verify();
        // unmapped address is refused
        apb(1'b0, 8'h3C, 32'h0000_0000);
        check({31'b0, rerr}, 32'h0000_0001);
        check(rdata, 32'h0000_0000);
        final_report();
    end
endmodule // gpo_port_tb
